// file: hw/tws_eeprom.sv
// Two-wire serial memory target: protocol engine, array, write timer
//
// What this block does
// - Sample on clock rise, drive after fall
// - Data line driven low or released only
// - Write protect high blocks all programming
// - 2048 bytes, 11-bit word address
// - Data fall with clock high is start
// - Data rise with clock high is stop
// - Data change during clock high is condition
// - Acknowledge each received byte on ninth clock
// - Address byte: type code, three page bits
// - Last address bit selects read or write
// - Wrong type code: no acknowledge, idle
// - Byte write: address, word, data, stop
// - Ignore bus during timed programming cycle
// - Page write up to sixteen bytes
// - Writes wrap within low four bits
// - No acknowledge while busy for polling
// - Counter holds last address plus one
// - Reads wrap from top to zero
// - Current read: ack, shift byte out
// - Master ack continues read, nack ends
`include "tws_params.svh"
`default_nettype none
module tws_eeprom
    import tws_pkg::*;
#(
    parameter int unsigned WR_CYCLES = `TWS_WR_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Write protect pin
    input wire logic wp_in,
    // Status
    output logic busy
);
    // ****************************************************************
    // Input synchronisation and condition detection
    // ****************************************************************
    logic [2:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    tws_sync #(.WIDTH(3)) u_sync (
        .clock(clock),
        .reset(reset),
        .pin_in({scl_in, sda_in, wp_in}),
        .level_out(pins_s)
    );

    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    assign wp_s = pins_s[0];
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

    always_ff @(posedge clock) begin
        if (reset) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // ****************************************************************
    // Address helpers
    // ****************************************************************
    function automatic logic [10:0] tws_page_inc(input logic [10:0] a);
        tws_page_inc = {a[10:4], a[3:0] + 4'h1};
    endfunction : tws_page_inc

    function automatic logic [10:0] tws_lin_inc(input logic [10:0] a);
        tws_lin_inc = a + 11'h001;
    endfunction : tws_lin_inc

    // ****************************************************************
    // Memory array and page buffer
    // ****************************************************************
    logic [7:0] mem_q [`TWS_MEM_WORDS];
    logic [7:0] page_q [`TWS_PAGE_BYTES];
    logic [15:0] pvalid_q;
    logic [15:0] pvalid_d;
    logic [6:0] prow_q;
    logic [6:0] prow_d;
    logic pbuf_we;
    logic [3:0] pbuf_idx;
    logic [7:0] pbuf_byte;
    logic commit;

    // ****************************************************************
    // Protocol state
    // ****************************************************************
    tws_state_e state_q;
    tws_state_e state_d;
    tws_state_e after_ack_q;
    tws_state_e after_ack_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [10:0] addr_q;
    logic [10:0] addr_d;
    logic [2:0] page_hi_q;
    logic [2:0] page_hi_d;
    logic drive_low_q;
    logic drive_low_d;
    logic nack_q;
    logic nack_d;
    logic pend_q;
    logic pend_d;
    logic [23:0] timer_q;
    logic [23:0] timer_d;
    logic busy_q;
    logic busy_d;

    always_comb begin
        state_d = state_q;
        after_ack_d = after_ack_q;
        shift_d = shift_q;
        bit_d = bit_q;
        addr_d = addr_q;
        page_hi_d = page_hi_q;
        drive_low_d = drive_low_q;
        nack_d = nack_q;
        pend_d = pend_q;
        timer_d = timer_q;
        busy_d = busy_q;
        pvalid_d = pvalid_q;
        prow_d = prow_q;
        pbuf_we = 1'b0;
        pbuf_idx = addr_q[3:0];
        pbuf_byte = shift_q;
        commit = 1'b0;
        if (busy_q) begin
            // Bus ignored until the write timer expires
            state_d = TWS_IDLE;
            drive_low_d = 1'b0;
            if (timer_q == 24'h00_0000) begin
                busy_d = 1'b0;
            end else begin
                timer_d = timer_q - 24'h00_0001;
            end
        end else if (stop_det) begin
            state_d = TWS_IDLE;
            drive_low_d = 1'b0;
            if (pend_q) begin
                pend_d = 1'b0;
                commit = 1'b1;
                busy_d = 1'b1;
                timer_d = 24'(WR_CYCLES - 1);
            end
        end else if (start_det) begin
            state_d = TWS_DEV;
            bit_d = 4'h0;
            drive_low_d = 1'b0;
            pend_d = 1'b0; // Repeated start abandons an unfinished write
            pvalid_d = 16'h0000;
        end else if (state_q != TWS_IDLE && scl_rise) begin
            unique case (state_q)
                TWS_DEV, TWS_WADDR, TWS_WDATA: begin
                    shift_d = {shift_q[6:0], sda_s};
                    bit_d = bit_q + 4'h1;
                end
                TWS_ACK_IN: begin
                    nack_d = sda_s;
                end
                default: begin
                end
            endcase
        end else if (state_q != TWS_IDLE && scl_fall) begin
            unique case (state_q)
                TWS_DEV: begin
                    if (bit_q == 4'h8) begin
                        if (shift_q[7:4] != `TWS_TYPE_CODE) begin
                            state_d = TWS_IDLE;
                        end else begin
                            page_hi_d = shift_q[3:1];
                            drive_low_d = 1'b1;
                            state_d = TWS_ACK_OUT;
                            if (shift_q[0]) begin
                                after_ack_d = TWS_RDATA;
                                addr_d = {shift_q[3:1], addr_q[7:0]};
                            end else begin
                                after_ack_d = TWS_WADDR;
                            end
                        end
                    end
                end
                TWS_WADDR, TWS_WDATA: begin
                    if (bit_q == 4'h8) begin
                        drive_low_d = 1'b1;
                        state_d = TWS_ACK_OUT;
                        after_ack_d = TWS_WDATA;
                        if (state_q == TWS_WADDR) begin
                            addr_d = {page_hi_q, shift_q};
                        end else begin
                            // Protected data is acked but dropped
                            if (!wp_s) begin
                                pbuf_we = 1'b1;
                                prow_d = addr_q[10:4];
                                pvalid_d = pvalid_q | (16'h0001 << addr_q[3:0]);
                                pend_d = 1'b1;
                            end
                            addr_d = tws_page_inc(addr_q);
                        end
                    end
                end
                TWS_ACK_OUT: begin
                    bit_d = 4'h0;
                    state_d = after_ack_q;
                    if (after_ack_q == TWS_RDATA) begin
                        shift_d = mem_q[addr_q];
                        addr_d = tws_lin_inc(addr_q);
                        drive_low_d = !mem_q[addr_q][7];
                        bit_d = 4'h1;
                    end else begin
                        drive_low_d = 1'b0;
                    end
                end
                TWS_RDATA: begin
                    if (bit_q == 4'h8) begin
                        drive_low_d = 1'b0;
                        state_d = TWS_ACK_IN;
                    end else begin
                        drive_low_d = !shift_q[7 - bit_q[2:0]];
                        bit_d = bit_q + 4'h1;
                    end
                end
                TWS_ACK_IN: begin
                    if (nack_q) begin
                        state_d = TWS_IDLE;
                    end else begin
                        shift_d = mem_q[addr_q];
                        addr_d = tws_lin_inc(addr_q);
                        drive_low_d = !mem_q[addr_q][7];
                        bit_d = 4'h1;
                        state_d = TWS_RDATA;
                    end
                end
                default: begin
                    state_d = TWS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= TWS_IDLE;
            after_ack_q <= TWS_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            addr_q <= 11'h000;
            page_hi_q <= 3'h0;
            drive_low_q <= 1'b0;
            nack_q <= 1'b1;
            pend_q <= 1'b0;
            timer_q <= 24'h00_0000;
            busy_q <= 1'b0;
            pvalid_q <= 16'h0000;
            prow_q <= 7'h00;
        end else begin
            state_q <= state_d;
            after_ack_q <= after_ack_d;
            shift_q <= shift_d;
            bit_q <= bit_d;
            addr_q <= addr_d;
            page_hi_q <= page_hi_d;
            drive_low_q <= drive_low_d;
            nack_q <= nack_d;
            pend_q <= pend_d;
            timer_q <= timer_d;
            busy_q <= busy_d;
            pvalid_q <= pvalid_d;
            prow_q <= prow_d;
        end
    end

    // Array contents survive reset, as a nonvolatile store would
    always_ff @(posedge clock) begin
        if (pbuf_we) begin
            page_q[pbuf_idx] <= pbuf_byte;
        end
        if (commit) begin
            for (int i = 0; i < `TWS_PAGE_BYTES; i++) begin
                if (pvalid_q[i]) begin
                    mem_q[{prow_q, 4'(i)}] <= page_q[i];
                end
            end
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Open drain: the pin only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = drive_low_q;
    assign busy = busy_q;
endmodule : tws_eeprom
`default_nettype wire

// file: hw/tws_sync.sv
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module tws_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    // Synchronised levels
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] level_d;

    always_comb begin
        meta_d = pin_in;
        level_d = meta_q;
    end

    // Pins idle high, so reset to one avoids a false edge
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= '1;
            level_q <= '1;
        end else begin
            meta_q <= meta_d;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;
endmodule : tws_sync
`default_nettype wire

// file: shared/tws_params.svh
// Constants for the two-wire serial memory target
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_MEM_WORDS 2048
`define TWS_ADDR_W 11
`define TWS_TYPE_CODE 4'ha
`define TWS_PAGE_LOW_W 4
`define TWS_CLK_MHZ 20
`define TWS_WR_TIME_MS 5
`define TWS_WR_CYCLES (`TWS_WR_TIME_MS * 1000 * `TWS_CLK_MHZ)
`define TWS_PAGE_BYTES 16
`endif

// file: shared/tws_pkg.sv
// Types for the two-wire serial memory target
`default_nettype none
package tws_pkg;
    typedef enum logic [2:0] {
        TWS_IDLE,
        TWS_DEV,
        TWS_WADDR,
        TWS_WDATA,
        TWS_RDATA,
        TWS_ACK_OUT,
        TWS_ACK_IN
    } tws_state_e;
endpackage : tws_pkg
`default_nettype wire

// file: tb/tws_checker.sv
// Port checker for the two-wire serial memory target
`default_nettype none
module tws_checker #(
    parameter int unsigned WR_CYCLES = 50
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bus pins, write protect and status
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wp_in,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [31:0] span_q, span_d;
    logic [3:0] age_q, age_d;
    logic sda_p_q;
    // ****************************
    // Helper counters
    // ****************************
    always_comb begin
        span_d = busy ? span_q + 32'h0000_0001 : 32'h0000_0000;
        age_d = age_q + {3'h0, age_q != 4'hf};
        if (scl_in && sda_in && !sda_p_q) begin
            age_d = 4'h0;
        end
    end
    always_ff @(posedge clock) begin
        span_q <= reset ? 32'h0000_0000 : span_d;
        age_q <= reset ? 4'hf : age_d;
        sda_p_q <= reset ? 1'b1 : sda_in;
    end
    a_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    a_oe_scl_low: assert property (
        $changed(sda_oe) |-> !scl_in)
        else $error("data drive changed with clock high");
    a_busy_no_ack: assert property (busy |-> !sda_oe)
        else $error("bus driven during write cycle");
    a_wp_no_cycle: assert property (
        $rose(busy) |-> !$past(wp_in, 8))
        else $error("write cycle under write protect");
    a_busy_after_stop: assert property (
        $rose(busy) |-> age_q <= 4'h8)
        else $error("write cycle without a stop");
    a_busy_holds: assert property ($rose(busy) |=> busy[*8])
        else $error("write cycle cut short");
    a_busy_span: assert property (
        $fell(busy) |-> span_q >= WR_CYCLES && span_q <= WR_CYCLES + 1)
        else $error("write cycle length wrong");
    a_cond_release: assert property (
        scl_in && $changed(sda_in) |-> !sda_oe[*4])
        else $error("data held after start or stop");
    cover property ($rose(busy));
    cover property ($rose(sda_oe));
    cover property (wp_in && $fell(sda_oe));
endmodule : tws_checker
bind tws_eeprom tws_checker #(.WR_CYCLES(WR_CYCLES)) chk_u (
    .clock(clock), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .busy(busy));
`default_nettype wire

// file: tb/tws_eeprom_bench.sv
// Self-checking bench for the two-wire serial memory target
`default_nettype none
module tws_eeprom_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned WRC = 400;
    logic clock, reset, wp_in, scl, sda_low, sda_out, sda_oe, busy, obs_v;
    logic [7:0] obs, z, want;
    logic [7:0] exp_q[$];
    logic [7:0] wd [0:2];
    logic [7:0] rd [0:2];
    logic [31:0] rnd = 32'h0000_798d;
    int err_count, checks;
    // Released line is pulled up
    wire logic sda = !(sda_low || (sda_oe && !sda_out));
    tws_eeprom #(.WR_CYCLES(WRC)) dut_u (.clock(clock), .reset(reset),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .wp_in(wp_in), .busy(busy));
    tws_master m_u (.clock(clock), .scl(scl), .sda_low(sda_low),
        .sda(sda), .obs(obs), .obs_v(obs_v));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    function automatic logic [7:0] rand8();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd[7:0];
    endfunction : rand8
    task automatic check(input string what, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic see(input logic e);
        @(negedge clock);
        check("busy", {6'h00, sda_oe, busy}, {7'h00, e});
        @(posedge clock);
    endtask : see
    task automatic send(input logic [7:0] d, input logic a);
        exp_q.push_back({7'h00, a});
        m_u.tx(d);
    endtask : send
    task automatic addr_phase(input logic [10:0] a);
        m_u.start();
        send({4'ha, a[10:8], 1'b0}, 1'b0);
        send(a[7:0], 1'b0);
    endtask : addr_phase
    task automatic write_run(input logic [10:0] a, input int n);
        addr_phase(a);
        for (int i = 0; i < n; i++) send(wd[i], 1'b0);
        m_u.stop();
    endtask : write_run
    // Dummy write loads the address unless cur asks for the counter
    task automatic read_run(input logic [10:0] a, input int n, logic cur);
        if (!cur) begin
            addr_phase(a);
        end
        m_u.start();
        send({4'ha, a[10:8], 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(rd[i]);
            m_u.rx(i == n - 1);
        end
        m_u.stop();
    endtask : read_run
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 500) begin
            @(posedge clock);
            k++;
        end
        if (k == 500) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wait_idle
    // ****************************
    // Result watcher
    // ****************************
    always @(posedge clock) begin
        if (obs_v === 1'b1) begin
            want = exp_q.size() ? exp_q.pop_front() : 8'hxx;
            check("bus", obs, want);
        end
    end
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
    // ****************************
    // Main sequence
    // ****************************
    initial begin
        reset = 1'b1;
        wp_in = 1'b0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        see(1'b0);
        repeat (3) @(posedge clock);
        m_u.start();
        send(8'h5e, 1'b1);
        m_u.stop();
        for (int i = 0; i < 3; i++) wd[i] = rand8();
        rd = wd;
        write_run(11'h7fe, 3);
        see(1'b1);
        m_u.start();
        send(8'hae, 1'b1);
        m_u.stop();
        wait_idle();
        wd[0] = rand8();
        z = wd[0];
        write_run(11'h000, 1);
        wait_idle();
        rd[2] = z;
        read_run(11'h7fe, 3, 1'b0);
        rd[0] = rd[1];
        read_run(11'h7ff, 1, 1'b0);
        rd[0] = z;
        read_run(11'h000, 1, 1'b1);
        wp_in <= 1'b1;
        wd[0] = ~z;
        write_run(11'h000, 1);
        see(1'b0);
        wp_in <= 1'b0;
        read_run(11'h000, 1, 1'b0);
        // Third page byte must have wrapped to the start of its page
        rd[0] = wd[2];
        read_run(11'h7f0, 1, 1'b0);
        repeat (4) @(posedge clock);
        check("queue", 8'(exp_q.size()), 8'h00);
        tally_and_finish();
    end
endmodule : tws_eeprom_bench
`default_nettype wire

// file: tb/tws_master.sv
// Bus master model driving clock and open-drain data
`default_nettype none
module tws_master (
    // Clock
    input wire logic clock,
    // Bus pins
    output logic scl,
    output logic sda_low,
    input wire logic sda,
    // Answers seen on the bus
    output logic [7:0] obs,
    output logic obs_v
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        obs = 8'h00;
        obs_v = 1'b0;
    end
    task automatic hold();
        repeat (6) @(posedge clock);
    endtask : hold
    task automatic note(input logic [7:0] v);
        obs <= v;
        obs_v <= 1'b1;
        @(posedge clock);
        obs_v <= 1'b0;
    endtask : note
    // Data moves only while the clock is low
    task automatic put_bit(input logic b, output logic r);
        sda_low <= !b;
        hold();
        scl <= 1'b1;
        hold();
        r = sda;
        scl <= 1'b0;
        hold();
    endtask : put_bit
    task automatic start();
        sda_low <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b1;
        hold();
        scl <= 1'b0;
        hold();
    endtask : start
    task automatic stop();
        sda_low <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b0;
        hold();
    endtask : stop
    task automatic tx(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i], a);
        put_bit(1'b1, a);
        note({7'h00, a});
    endtask : tx
    // Last byte of a read gets no acknowledge
    task automatic rx(input logic last);
        logic [8:0] d;
        for (int i = 8; i >= 1; i--) put_bit(1'b1, d[i]);
        put_bit(last, d[0]);
        note(d[8:1]);
    endtask : rx
endmodule : tws_master
`default_nettype wire
